//--- inc/sfcfe_cfg.svh
// Opcodes, dummy counts, lane widths and masks of the flash command front end.
// Assumes inclusion by bare name from any design or package file.
`ifndef SFCFE_CFG_SVH
`define SFCFE_CFG_SVH
`define SFC_OP_READ 8'h03
`define SFC_OP_FAST 8'h0B
`define SFC_OP_DIO 8'hBB
`define SFC_OP_DOUT 8'h3B
`define SFC_OP_QIO 8'hEB
`define SFC_OP_QOUT 8'h6B
`define SFC_OP_QIOW 8'hE7
`define SFC_OP_PGM 8'h02
`define SFC_OP_QPGM 8'h38
`define SFC_OP_SECT 8'h20
`define SFC_OP_HALF 8'h52
`define SFC_OP_BLK 8'hD8
`define SFC_OP_CHIP0 8'h60
`define SFC_OP_CHIP1 8'hC7
`define SFC_OP_WSET 8'h06
`define SFC_OP_WCLR 8'h04
`define SFC_OP_QENT 8'h35
`define SFC_OP_QEXT 8'hF5
`define SFC_OP_SUS0 8'h75
`define SFC_OP_SUS1 8'hB0
`define SFC_OP_RSM0 8'h7A
`define SFC_OP_RSM1 8'h30
`define SFC_OP_PDN 8'hB9
`define SFC_OP_PUP 8'hAB
`define SFC_DUM_FAST 5'h08
`define SFC_DUM_DIO 5'h04
`define SFC_DUM_QIO 5'h06
`define SFC_DUM_QIOW 5'h04
`define SFC_DUM_NONE 5'h00
`define SFC_W1 3'h1
`define SFC_W2 3'h2
`define SFC_W4 3'h4
`define SFC_OE_X1 4'h2
`define SFC_OE_X2 4'h3
`define SFC_OE_X4 4'hF
`define SFC_BYTE_BITS 6'h08
`define SFC_ADDR_BITS 6'h18
`define SFC_ADDR_MASK 24'h07FFFF
`define SFC_SECT_MASK 24'h07F000
`define SFC_HALF_MASK 24'h078000
`define SFC_BLK_MASK 24'h070000
`define SFC_PGM_MAX 9'h100
`define SFC_PIN_RST 6'h20
`endif

//--- inc/sfcfe_pkg.sv
// Types of the flash command front end: frame states, command kinds, core state.
// Assumes sfcfe_cfg.svh is on the include path.
`default_nettype none
package sfcfe_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_OPC = 8'h02, ST_ADDR = 8'h04, ST_DUMMY = 8'h08,
    ST_DOUT = 8'h10, ST_DIN = 8'h20, ST_TAIL = 8'h40, ST_IGN = 8'h80
  } sfcfe_state_e;
  typedef enum logic [3:0] {
    K_NONE = 4'h1, K_READ = 4'h2, K_PROG = 4'h4, K_ERASE = 4'h8
  } sfcfe_kind_e;
  typedef struct packed {
    sfcfe_state_e st;
    sfcfe_kind_e kind;
    logic quad_cmd;
    logic wlatch;
    logic pdown;
    logic active;
    logic cs_q;
    logic sclk_q;
    logic [7:0] op;
    logic [7:0] sr;
    logic [7:0] osr;
    logic [5:0] cnt;
    logic [2:0] lane;
    logic [2:0] dlane;
    logic [4:0] dummy;
    logic [23:0] addr;
    logic [8:0] nbytes;
    logic [3:0] sio;
    logic [3:0] oe;
    logic ex_valid;
    logic [7:0] ex_op;
    logic [23:0] ex_addr;
    logic [8:0] ex_len;
    logic reject;
    logic rd_next;
    logic push;
    logic [7:0] pdata;
    logic ovf;
  } sfcfe_core_s;
endpackage
`default_nettype wire

//--- inc/sfcfe_stream_if.sv
// Valid/ready byte stream between the core and its buffer.
// Assumes one clock domain shared by both ends.
`default_nettype none
interface sfcfe_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- design/sfcfe_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes the pins are asynchronous to clk_i; only the second stage is used.
`default_nettype none
module sfcfe_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sfcfe_sync_s;
  sfcfe_sync_s s, n;

  always_comb begin
    n.meta = d_i;
    n.q = s.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= {RST_VAL, RST_VAL};
    end else begin
      s <= n;
    end
  end

  assign q_o = s.q;
endmodule
`default_nettype wire

//--- design/sfcfe_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; ready drops honestly when every slot is taken.
`default_nettype none
module sfcfe_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Streams
  sfcfe_stream_if.snk wr,
  sfcfe_stream_if.src rd
);
  localparam int AW = $clog2(D);
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sfcfe_fifo_s;
  sfcfe_fifo_s s, n;
  logic do_wr;
  logic do_rd;

  assign wr.ready = (s.cnt != FULL);
  assign rd.valid = (s.cnt != '0);
  assign rd.data = s.mem[s.rp];
  assign do_wr = wr.valid && wr.ready;
  assign do_rd = rd.valid && rd.ready;

  always_comb begin
    n = s;
    if (do_wr) begin
      n.mem[s.wp] = wr.data;
      n.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
    end
    if (do_rd) begin
      n.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
    end
    if (do_wr && !do_rd) begin
      n.cnt = s.cnt + 1'b1;
    end else if (!do_wr && do_rd) begin
      n.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule
`default_nettype wire

//--- design/sfcfe_top.sv
// Serial flash command front end: opcode decode, frame tracking, dispatch.
// Assumes pins are asynchronous and slow against clk_i (link clock >= 8 clk periods).
`default_nettype none
`include "sfcfe_cfg.svh"

// Contract
// [RULE1] Array spans 07FFFFh; erase addresses size-aligned
// [RULE2] Invalid opcode: standby, output off, wait
// [RULE3] Valid opcode: active until select rises
// [RULE4] Sample on clock rise, drive on fall
// [RULE5] Reads stream out, end at any bit
// [RULE6] Write-type commands must end on bytes
// [RULE7] Busy device ignores array access commands; chip erase (60h, C7h) is still accepted while busy
// [RULE8] Host polls status before each command
// [RULE9] Opcode 35h enters quad protocol, single-line only
// [RULE10] Opcode F5h leaves quad protocol, quad only
// [RULE11] Quad protocol moves four bits per clock
// [RULE12] 03 plain read, 0B fast read
// [RULE13] BB, EB, 3B, 6B multi-line reads decoded
// [RULE14] E7 quad read, four fixed dummy clocks
// [RULE15] 02 and 38 program pages
// [RULE16] Sector, half-block, block and chip erase
// [RULE17] Suspend and resume opcodes, address free
// [RULE18] B9 powers down, AB releases
// [RULE19] Write latch required before modifying commands
// [RULE20] Configuration bits stretch marked dummy counts
// [RULE21] Address and bits most significant first
module sfcfe_top #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] sio_i,
  output logic [3:0] sio_o,
  output logic [3:0] sio_oe_o,
  // Configuration and status
  input wire logic busy_i,
  input wire logic dummy_count_low_bit_i,
  input wire logic dummy_count_high_bit_i,
  output logic quad_command_protocol_o,
  output logic write_latch_bit_o,
  output logic deep_power_down_o,
  output logic active_o,
  // Command dispatch
  output logic exec_valid_o,
  output logic [7:0] exec_op_o,
  output logic [23:0] exec_addr_o,
  output logic [8:0] exec_len_o,
  output logic cmd_reject_o,
  // Read data
  input wire logic [7:0] rd_data_i,
  output logic rd_next_o,
  // Program data
  output logic [7:0] pgm_data_o,
  output logic pgm_valid_o,
  input wire logic pgm_ready_i,
  output logic pgm_overflow_o
);
  import sfcfe_pkg::*;

  sfcfe_core_s s, n;
  logic [5:0] pins_s;
  logic cs_s;
  logic sclk_s;
  logic [3:0] sio_s;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic [4:0] dum_adj;

  sfcfe_stream_if #(.W(8)) pgm_in ();
  sfcfe_stream_if #(.W(8)) pgm_out ();

  sfcfe_sync #(.W(6), .RST_VAL(`SFC_PIN_RST)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({cs_n_i, sclk_i, sio_i}),
    .q_o(pins_s)
  );

  // Program bytes wait here for the array side
  sfcfe_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr(pgm_in),
    .rd(pgm_out)
  );

  assign {cs_s, sclk_s, sio_s} = pins_s;
  assign cs_rise = cs_s && !s.cs_q;
  assign cs_fall = !cs_s && s.cs_q;
  assign sclk_rise = sclk_s && !s.sclk_q; // see [RULE4]
  assign sclk_fall = !sclk_s && s.sclk_q;
  assign dum_adj = {2'h0, dummy_count_high_bit_i, dummy_count_low_bit_i, 1'b0}; // see [RULE20]

  ////////////////////////////////////////////////////////////////////////////
  // Lane-width shift, most significant bits first
  function automatic logic [23:0] shin(input logic [23:0] v, input logic [2:0] w,
                                       input logic [3:0] b);
    logic [23:0] r;
    r = {v[22:0], b[0]};
    if (w == `SFC_W2) begin
      r = {v[21:0], b[1:0]};
    end else if (w == `SFC_W4) begin
      r = {v[19:0], b};
    end
    return r;
  endfunction

  function automatic logic [23:0] align(input logic [7:0] op, input logic [23:0] a);
    logic [23:0] r;
    r = a & `SFC_ADDR_MASK;
    if (op == `SFC_OP_SECT) begin
      r = a & `SFC_SECT_MASK;
    end else if (op == `SFC_OP_HALF) begin
      r = a & `SFC_HALF_MASK;
    end else if (op == `SFC_OP_BLK) begin
      r = a & `SFC_BLK_MASK;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [23:0] sh_a;
    logic [23:0] sh_b;
    logic [5:0] cnt_w;
    logic [7:0] opc;
    logic [7:0] ob;
    logic [2:0] ql;
    logic v_ok;
    sfcfe_kind_e v_kind;
    logic [2:0] v_al;
    logic [2:0] v_dl;
    logic [4:0] v_dum;
    n = s;
    sh_a = shin(s.addr, s.lane, sio_s); // see [RULE21]
    sh_b = shin({16'h0000, s.sr}, s.lane, sio_s);
    cnt_w = s.cnt + {3'h0, s.lane};
    opc = sh_b[7:0];
    ob = (s.cnt == '0) ? rd_data_i : s.osr;
    ql = s.quad_cmd ? `SFC_W4 : `SFC_W1; // see [RULE11]
    v_ok = 1'b1;
    v_kind = K_READ;
    v_al = ql;
    v_dl = ql;
    v_dum = `SFC_DUM_NONE;
    n.cs_q = cs_s;
    n.sclk_q = sclk_s;
    n.ex_valid = 1'b0;
    n.reject = 1'b0;
    n.rd_next = 1'b0;
    n.push = 1'b0;
    if (cs_rise) begin
      n.st = ST_IDLE;
      n.active = 1'b0;
      n.oe = '0; // see [RULE5]
      if ((s.st == ST_TAIL && s.cnt == '0) ||
          (s.st == ST_DIN && s.cnt == '0 && s.nbytes != '0)) begin
        n.ex_op = s.op;
        n.ex_addr = align(s.op, s.addr);
        n.ex_len = s.nbytes;
        unique case (s.op)
          `SFC_OP_WSET: n.wlatch = 1'b1; // see [RULE19]
          `SFC_OP_WCLR: n.wlatch = 1'b0;
          `SFC_OP_QENT: n.quad_cmd = 1'b1; // see [RULE9]
          `SFC_OP_QEXT: n.quad_cmd = 1'b0; // see [RULE10]
          `SFC_OP_PDN: n.pdown = 1'b1; // see [RULE18]
          `SFC_OP_PUP: n.pdown = 1'b0;
          `SFC_OP_SUS0, `SFC_OP_SUS1: begin // see [RULE17]
            n.ex_valid = 1'b1;
            n.wlatch = 1'b0;
          end
          `SFC_OP_RSM0, `SFC_OP_RSM1: n.ex_valid = 1'b1;
          default: begin
            // Program and erase opcodes need the latch and consume it
            n.ex_valid = s.wlatch; // see [RULE19] [RULE15] [RULE16]
            n.reject = !s.wlatch;
            n.wlatch = 1'b0;
          end
        endcase
      end else if (s.st == ST_TAIL || s.st == ST_DIN ||
                   (s.st == ST_ADDR && s.kind != K_READ)) begin
        n.reject = 1'b1; // see [RULE6]
      end
    end else if (cs_fall) begin
      n.st = ST_OPC;
      n.cnt = '0;
      n.lane = ql;
      n.nbytes = '0;
      n.ovf = 1'b0;
    end else if (!cs_s && sclk_rise) begin
      unique case (s.st)
        ST_OPC: begin
          n.sr = opc;
          n.cnt = cnt_w;
          if (cnt_w == `SFC_BYTE_BITS) begin
            n.op = opc;
            n.cnt = '0;
            unique case (opc)
              `SFC_OP_READ: v_ok = !s.quad_cmd; // see [RULE12]
              `SFC_OP_FAST: v_dum = `SFC_DUM_FAST + dum_adj;
              `SFC_OP_DIO: begin // see [RULE13]
                v_ok = !s.quad_cmd;
                v_al = `SFC_W2;
                v_dl = `SFC_W2;
                v_dum = `SFC_DUM_DIO + dum_adj;
              end
              `SFC_OP_DOUT: begin
                v_ok = !s.quad_cmd;
                v_dl = `SFC_W2;
                v_dum = `SFC_DUM_FAST + dum_adj;
              end
              `SFC_OP_QOUT: begin
                v_ok = !s.quad_cmd;
                v_dl = `SFC_W4;
                v_dum = `SFC_DUM_FAST + dum_adj;
              end
              `SFC_OP_QIO: begin
                v_al = `SFC_W4;
                v_dl = `SFC_W4;
                v_dum = `SFC_DUM_QIO + dum_adj;
              end
              `SFC_OP_QIOW: begin // see [RULE14]
                v_ok = !s.quad_cmd;
                v_al = `SFC_W4;
                v_dl = `SFC_W4;
                v_dum = `SFC_DUM_QIOW;
              end
              `SFC_OP_PGM: v_kind = K_PROG;
              `SFC_OP_QPGM: begin
                v_ok = !s.quad_cmd;
                v_kind = K_PROG;
                v_dl = `SFC_W4;
              end
              `SFC_OP_SECT, `SFC_OP_HALF, `SFC_OP_BLK: v_kind = K_ERASE;
              `SFC_OP_QENT: begin
                v_ok = !s.quad_cmd;
                v_kind = K_NONE;
              end
              `SFC_OP_QEXT: begin
                v_ok = s.quad_cmd;
                v_kind = K_NONE;
              end
              `SFC_OP_CHIP0, `SFC_OP_CHIP1, `SFC_OP_WSET, `SFC_OP_WCLR, `SFC_OP_SUS0,
              `SFC_OP_SUS1, `SFC_OP_RSM0, `SFC_OP_RSM1, `SFC_OP_PDN, `SFC_OP_PUP:
                v_kind = K_NONE;
              default: v_ok = 1'b0;
            endcase
            // Power-down hears only its release; busy array blocks access except chip erase
            n.st = ST_IGN; // see [RULE2]
            if (v_ok && (!s.pdown || opc == `SFC_OP_PUP) &&
                !(busy_i && v_kind != K_NONE)) begin // see [RULE7]
              n.active = 1'b1; // see [RULE3]
              n.kind = v_kind;
              n.lane = v_al;
              n.dlane = v_dl;
              n.dummy = v_dum;
              n.st = (v_kind == K_NONE) ? ST_TAIL : ST_ADDR;
            end
          end
        end
        ST_ADDR: begin
          n.addr = sh_a;
          n.cnt = cnt_w;
          if (cnt_w == `SFC_ADDR_BITS) begin
            n.cnt = '0;
            n.lane = s.dlane;
            n.st = ST_TAIL;
            if (s.kind == K_READ) begin
              n.ex_valid = 1'b1;
              n.ex_op = s.op;
              n.ex_addr = sh_a & `SFC_ADDR_MASK; // see [RULE1]
              n.st = (s.dummy == `SFC_DUM_NONE) ? ST_DOUT : ST_DUMMY;
            end else if (s.kind == K_PROG) begin
              n.st = ST_DIN;
            end
          end
        end
        ST_DUMMY: begin
          n.cnt = s.cnt + 1'b1;
          if (n.cnt == {1'b0, s.dummy}) begin
            n.cnt = '0;
            n.st = ST_DOUT;
          end
        end
        ST_DIN: begin
          n.sr = opc;
          n.cnt = cnt_w;
          if (cnt_w == `SFC_BYTE_BITS) begin
            n.cnt = '0;
            n.push = pgm_in.ready;
            n.pdata = opc;
            n.ovf = s.ovf || !pgm_in.ready;
            n.nbytes = (s.nbytes == `SFC_PGM_MAX) ? s.nbytes : s.nbytes + 1'b1;
          end
        end
        // Any clock past the last whole byte spoils the command
        ST_TAIL: n.cnt = s.cnt | {3'h0, s.lane}; // see [RULE6]
        default: n.cnt = s.cnt;
      endcase
    end else if (!cs_s && sclk_fall && s.st == ST_DOUT) begin
      n.rd_next = (s.cnt == '0);
      n.sio = {ob[7:4]};
      n.oe = `SFC_OE_X4;
      if (s.lane == `SFC_W1) begin
        n.sio = {2'h0, ob[7], 1'b0};
        n.oe = `SFC_OE_X1;
      end else if (s.lane == `SFC_W2) begin
        n.sio = {2'h0, ob[7:6]};
        n.oe = `SFC_OE_X2;
      end
      n.osr = ob << s.lane;
      n.cnt = (cnt_w == `SFC_BYTE_BITS) ? '0 : cnt_w;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.kind <= K_NONE;
      s.cs_q <= 1'b1;
      s.lane <= `SFC_W1;
      s.dlane <= `SFC_W1;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pgm_in.valid = s.push;
  assign pgm_in.data = s.pdata;
  assign pgm_out.ready = pgm_ready_i;
  assign pgm_data_o = pgm_out.data;
  assign pgm_valid_o = pgm_out.valid;
  assign pgm_overflow_o = s.ovf;
  assign sio_o = s.sio;
  assign sio_oe_o = s.oe;
  assign quad_command_protocol_o = s.quad_cmd;
  assign write_latch_bit_o = s.wlatch;
  assign deep_power_down_o = s.pdown;
  assign active_o = s.active;
  assign exec_valid_o = s.ex_valid;
  assign exec_op_o = s.ex_op;
  assign exec_addr_o = s.ex_addr;
  assign exec_len_o = s.ex_len;
  assign cmd_reject_o = s.reject;
  assign rd_next_o = s.rd_next;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_ign_quiet;
    (s.st == ST_IGN) |-> (sio_oe_o == '0 && !active_o);
  endproperty
  a_ign_quiet: assert property (p_ign_quiet) else $error("output driven in standby"); // see [RULE2]

  property p_active_hold;
    (active_o && !cs_rise) |=> active_o;
  endproperty
  a_active_hold: assert property (p_active_hold) else $error("active dropped early"); // see [RULE3]

  property p_rise_ends;
    cs_rise |=> (sio_oe_o == '0 && !active_o && s.st == ST_IDLE);
  endproperty
  a_rise_ends: assert property (p_rise_ends) else $error("frame not ended"); // see [RULE5]

  property p_drive_on_fall;
    $changed(sio_oe_o) && sio_oe_o != '0 |-> $past(sclk_fall);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("drive off fall"); // see [RULE4]

  property p_tail_reject;
    (cs_rise && s.st == ST_TAIL && s.cnt != '0) |=> (cmd_reject_o && !exec_valid_o);
  endproperty
  a_tail_reject: assert property (p_tail_reject) else $error("ragged end accepted"); // see [RULE6]

  property p_quad_enter;
    (cs_rise && s.st == ST_TAIL && s.cnt == '0 && s.op == `SFC_OP_QENT) |=>
      quad_command_protocol_o ##1 quad_command_protocol_o;
  endproperty
  a_quad_enter: assert property (p_quad_enter) else $error("quad entry missed"); // see [RULE9]

  property p_quad_exit;
    (cs_rise && s.st == ST_TAIL && s.cnt == '0 && s.op == `SFC_OP_QEXT) |=>
      !quad_command_protocol_o;
  endproperty
  a_quad_exit: assert property (p_quad_exit) else $error("quad exit missed"); // see [RULE10]

  property p_busy_block;
    (s.st == ST_OPC && n.st == ST_ADDR) |-> !busy_i;
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("access while busy"); // see [RULE7]

  property p_latch_used;
    (exec_valid_o && (exec_op_o == `SFC_OP_PGM || exec_op_o == `SFC_OP_SECT)) |->
      ($past(write_latch_bit_o, 2) && !write_latch_bit_o);
  endproperty
  a_latch_used: assert property (p_latch_used) else $error("latch not honoured"); // see [RULE19]

  property p_sect_align;
    (exec_valid_o && exec_op_o == `SFC_OP_SECT) |-> (exec_addr_o & ~`SFC_SECT_MASK) == '0;
  endproperty
  a_sect_align: assert property (p_sect_align) else $error("erase misaligned"); // see [RULE1]

  property p_short_wait;
    (s.st == ST_ADDR && n.st == ST_DUMMY && s.op == `SFC_OP_QIOW) |=>
      (s.dummy == `SFC_DUM_QIOW && s.lane == `SFC_W4);
  endproperty
  a_short_wait: assert property (p_short_wait) else $error("wrong short wait"); // see [RULE14]
endmodule
`default_nettype wire

//--- tb/sfcfe_host.sv
// Host serial master model: select, mode-0 clock and data lanes.
// Assumes one caller at a time and a pin level resolved by the bench.
`default_nettype none
module sfcfe_host (
  // Clock
  input wire logic clk_i,
  // Pins
  input wire logic [3:0] sio_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] hd_o,
  output logic [3:0] hoe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    hd_o = 4'h0;
    hoe_o = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Data moves while low, level read just before the rise
  task automatic cyc(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] s);
    @(posedge clk_i);
    hd_o <= d;
    hoe_o <= oe;
    #58;
    s = sio_i;
    @(posedge clk_i);
    sclk_o <= 1'b1;
    #58;
    @(posedge clk_i);
    sclk_o <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b, input bit q);
    logic [3:0] s;
    if (q) begin
      cyc(b[7:4], 4'hF, s);
      cyc(b[3:0], 4'hF, s);
    end else begin
      for (int i = 7; i >= 0; i--) cyc({3'h0, b[i]}, 4'h1, s);
    end
  endtask
  task automatic idle(input int n);
    logic [3:0] s;
    repeat (n) cyc(4'h0, 4'h0, s);
  endtask
  task automatic recv(output logic [7:0] b);
    logic [3:0] s;
    for (int i = 7; i >= 0; i--) begin
      cyc(4'h0, 4'h0, s);
      b[i] = s[1];
    end
  endtask
  task automatic start();
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // Callers end write-type frames on whole bytes unless a refusal is wanted
  task automatic stop();
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    hoe_o <= 4'h0;
    repeat (12) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench of the flash command front end.
// Assumes the host model owns the pins and the bench plays the array side.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic busy_i = 1'b0;
  logic dlo = 1'b0;
  logic dhi = 1'b0;
  logic pgm_ready_i = 1'b0;
  logic alt = 1'b0;
  logic [7:0] rd_data_i = 8'h00;
  logic cs_n_i, sclk_i;
  logic [3:0] hd, hoe, sio_i, sio_o, sio_oe_o;
  logic quad_command_protocol_o, write_latch_bit_o, deep_power_down_o, active_o;
  logic exec_valid_o, cmd_reject_o, rd_next_o, pgm_valid_o, pgm_overflow_o;
  logic [7:0] exec_op_o, pgm_data_o, b, nb;
  logic [23:0] exec_addr_o, a;
  logic [8:0] exec_len_o;
  logic [3:0] q1, q0;
  int err_total = 0, samples_checked = 0, n_exec = 0, n_rej = 0, k;
  logic [7:0] rq[$], pq[$], eq[$];
  logic [7:0] ops[9] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h75, 8'hB0, 8'h7A, 8'h30};
  always #5 clk_i = ~clk_i;
  // Upper lanes pulled up; released lower lanes keep moving
  assign sio_i = (hd & hoe) | (sio_o & sio_oe_o & ~hoe)
    | ({2'b11, alt, ~alt} & ~(hoe | sio_oe_o));
  sfcfe_host host (.clk_i, .sio_i, .cs_n_o(cs_n_i), .sclk_o(sclk_i), .hd_o(hd), .hoe_o(hoe));
  sfcfe_top #(.FIFO_DEPTH(8)) u_sfcfe_top (.clk_i, .rst_n_i, .cs_n_i, .sclk_i, .sio_i, .sio_o,
    .sio_oe_o, .busy_i, .dummy_count_low_bit_i(dlo), .dummy_count_high_bit_i(dhi),
    .quad_command_protocol_o, .write_latch_bit_o, .deep_power_down_o, .active_o,
    .exec_valid_o, .exec_op_o, .exec_addr_o, .exec_len_o, .cmd_reject_o, .rd_data_i,
    .rd_next_o, .pgm_data_o, .pgm_valid_o, .pgm_ready_i, .pgm_overflow_o);
  ////////////////////////////////////////////////////////////////////////////////
  // Array side: a fresh random byte each time one is taken
  always @(posedge clk_i) begin
    alt <= ~alt;
    if (exec_valid_o) n_exec++;
    if (cmd_reject_o) n_rej++;
    if (pgm_valid_o && pgm_ready_i) pq.push_back(pgm_data_o);
    if (exec_valid_o || rd_next_o) begin
      nb = 8'($urandom);
      rd_data_i <= nb;
      rq.push_back(nb);
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask
  function automatic logic [23:0] amask(input logic [7:0] op, input logic [23:0] v);
    case (op)
      8'h20: return v & 24'h07F000;
      8'h52: return v & 24'h078000;
      8'hD8: return v & 24'h070000;
      default: return v & 24'h07FFFF;
    endcase
  endfunction
  task automatic cmd(input logic [7:0] op, input bit ad, input logic [23:0] v, input bit q);
    host.start();
    host.send(op, q);
    if (ad) for (int i = 2; i >= 0; i--) host.send(v[8*i +: 8], q);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #800000;
    err_total++;
    final_report();
  end
  initial begin
    k = $urandom(20929);
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("idle", {sio_oe_o, quad_command_protocol_o, write_latch_bit_o}, 0);
    chk("idle pd", deep_power_down_o, 0);
    foreach (ops[i]) begin
      a = $urandom;
      k = n_exec;
      cmd(8'h06, 0, 0, 0);
      host.stop();
      chk("latch set", write_latch_bit_o, 1);
      cmd(ops[i], i < 3, a, 0);
      host.stop();
      chk("exec count", n_exec - k, 1);
      chk("exec op", exec_op_o, ops[i]);
      if (i < 3) chk("exec addr", exec_addr_o, amask(ops[i], a));
      // Resume leaves the latch alone; every other opcode here consumes it
      chk("latch used", write_latch_bit_o, i > 6);
    end
    $display("test dispatch done");
    cmd(8'h04, 0, 0, 0);
    host.stop();
    k = n_rej;
    cmd(8'h20, 1, a, 0);
    host.stop();
    cmd(8'h06, 0, 0, 0);
    host.idle(1);
    host.stop();
    chk("reject count", n_rej - k, 2);
    chk("latch kept", write_latch_bit_o, 0);
    cmd(8'hFF, 0, 0, 0);
    host.idle(8);
    chk("standby", {sio_oe_o, active_o}, 0);
    host.stop();
    $display("test refusal done");
    rq.delete();
    cmd(8'h03, 1, a, 0);
    chk("active", active_o, 1);
    chk("read op", {exec_op_o, exec_addr_o}, {8'h03, amask(8'h03, a)});
    for (int j = 0; j < 2; j++) begin
      host.recv(b);
      chk("read data", b, rq[j]);
    end
    host.idle(3);
    host.stop();
    chk("read end", sio_oe_o, 0);
    {dhi, dlo} <= 2'($urandom);
    rq.delete();
    cmd(8'h0B, 1, a, 0);
    host.idle(8 + 2 * {dhi, dlo});
    host.recv(b);
    chk("fast data", b, rq[0]);
    host.stop();
    // Short-wait quad read ignores the dummy-count bits
    rq.delete();
    host.start();
    host.send(8'hE7, 0);
    for (int i = 2; i >= 0; i--) host.send(a[8*i +: 8], 1);
    chk("short op", {exec_op_o, exec_addr_o}, {8'hE7, amask(8'hE7, a)});
    host.idle(4);
    host.cyc(4'h0, 4'h0, q1);
    host.cyc(4'h0, 4'h0, q0);
    chk("short data", {q1, q0}, rq[0]);
    host.stop();
    busy_i <= 1'b1;
    k = n_exec;
    cmd(8'h03, 1, a, 0);
    chk("busy active", active_o, 0);
    host.stop();
    chk("busy exec", n_exec - k, 0);
    busy_i <= 1'b0;
    $display("test read done");
    cmd(8'h06, 0, 0, 0);
    host.stop();
    pq.delete();
    cmd(8'h02, 1, a, 0);
    for (int j = 0; j < 9; j++) begin
      b = $urandom;
      if (j < 8) eq.push_back(b);
      host.send(b, 0);
    end
    host.stop();
    chk("pgm len", {exec_op_o, exec_len_o}, {8'h02, 9'h009});
    chk("overflow", pgm_overflow_o, 1);
    pgm_ready_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    pgm_ready_i <= 1'b0;
    chk("drained", {pgm_valid_o, 8'(pq.size())}, 8);
    foreach (eq[j]) chk("pgm byte", pq[j], eq[j]);
    $display("test program done");
    cmd(8'h35, 0, 0, 0);
    host.stop();
    chk("quad on", quad_command_protocol_o, 1);
    cmd(8'h06, 0, 0, 1);
    host.stop();
    chk("quad latch", write_latch_bit_o, 1);
    cmd(8'h04, 0, 0, 1);
    host.stop();
    cmd(8'hF5, 0, 0, 1);
    host.stop();
    chk("quad off", {quad_command_protocol_o, write_latch_bit_o}, 0);
    cmd(8'hB9, 0, 0, 0);
    host.stop();
    cmd(8'h06, 0, 0, 0);
    host.stop();
    chk("asleep", {deep_power_down_o, write_latch_bit_o}, 2);
    cmd(8'hAB, 0, 0, 0);
    host.stop();
    chk("awake", deep_power_down_o, 0);
    $display("test mode done");
    final_report();
  end
endmodule
`default_nettype wire
